// ===== pkg/sec_pf_pkg.sv
// Shared constants and types for the secondary prefetch and flow-through control block
package sec_pf_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------------
    // Register indices and byte addresses (byte address = 4 x index)
    // ------------------------------------------------------------------
    localparam logic [7:0]        IDX_INCR  = 8'h4b;
    localparam logic [7:0]        IDX_MAX   = 8'h4d;
    localparam logic [7:0]        IDX_FLOW  = 8'h4e;
    localparam logic [7:0]        IDX_STAT  = 8'h50;
    localparam logic [ADDR_W-1:0] ADDR_INCR = {IDX_INCR, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_MAX  = {IDX_MAX, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_FLOW = {IDX_FLOW, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_STAT = {IDX_STAT, 2'b00};

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int         PW_WAIT_LSB   = 0;
    localparam int         DR_WAIT_LSB   = 4;
    localparam logic [5:0] RST_MAX       = 6'h20;
    localparam logic [5:0] RST_INCR      = 6'h10;
    localparam logic [2:0] RST_PW_WAIT   = 3'h0;
    localparam logic [2:0] RST_DR_WAIT   = 3'h0;
    localparam logic [6:0] MAX_PF_DWORDS = 7'h40;
    localparam logic [7:0] USED_SAT      = 8'hff;

    // ------------------------------------------------------------------
    // Carriers and states
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       active;
        logic [6:0] level;
        logic       refill;
    } flow_in_t;

    typedef struct packed {
        logic hold;
        logic term;
    } flow_out_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK  = 2'b01
    } bus_state_t;

    typedef enum logic [1:0] {
        WT_IDLE = 2'b00,
        WT_WAIT = 2'b01,
        WT_DONE = 2'b10
    } wait_state_t;

endpackage

// ===== src/flow_wait_timer.sv
// Flow-through wait timer: stalls a starved burst, then ends it after the coded number of clocks unless refilled; code 0 ends it with one entry left
`timescale 1ns/1ps
module flow_wait_timer (
    input  wire logic                  i_clk,
    input  wire logic                  i_sys_rst,
    input  wire logic [2:0]            i_code,
    input  wire sec_pf_pkg::flow_in_t  i_flow,
    output      sec_pf_pkg::flow_out_t o_flow
);
    import sec_pf_pkg::*;

    wait_state_t state;
    wait_state_t next_state;
    logic [2:0]  cnt;
    logic [2:0]  next_cnt;
    flow_out_t   next_flow;

    // ------------------------------------------------------------------
    // Wait sequencing
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_flow  = '0;
        case (state)
            WT_IDLE: begin
                if (i_flow.active) begin
                    if (i_code == 3'h0) begin
                        if (i_flow.level == 7'h01) begin // see RULE8 see RULE12
                            next_flow.term = 1'b1;
                            next_state     = WT_DONE;
                        end
                    end else if (i_flow.level == 7'h00) begin // see RULE9 see RULE13
                        next_flow.hold = 1'b1;
                        next_cnt       = 3'h1;
                        next_state     = WT_WAIT;
                    end
                end
            end
            WT_WAIT: begin
                next_cnt = 3'h0;
                if (!i_flow.active || i_flow.refill) begin
                    next_state = WT_IDLE;
                end else if (cnt == i_code) begin // see RULE7 see RULE11 see RULE15
                    next_flow.term = 1'b1;
                    next_state     = WT_DONE;
                end else begin
                    next_cnt       = cnt + 3'h1;
                    next_flow.hold = 1'b1;
                end
            end
            WT_DONE: begin
                // Stay quiet until the burst is closed, one end per burst
                if (!i_flow.active) begin
                    next_state = WT_IDLE;
                end
            end
            default: begin
                next_state = WT_IDLE;
                next_cnt   = 3'h0;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state  <= WT_IDLE;
            cnt    <= 3'h0;
            o_flow <= '0;
        end else begin
            state  <= next_state;
            cnt    <= next_cnt;
            o_flow <= next_flow;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    wait_expire_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE7
        (state == WT_WAIT && cnt == i_code && i_flow.active && !i_flow.refill) |=> (o_flow.term && !o_flow.hold))
        else $error("wait expiry did not end the cycle");
    zero_code_end_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE8
        (state == WT_IDLE && i_flow.active && i_code == 3'h0 && i_flow.level == 7'h01) |=> o_flow.term)
        else $error("code zero did not end at one entry");
    one_clock_wait_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE9
        (state == WT_IDLE && i_flow.active && i_code == 3'h1 && i_flow.level == 7'h00)
        ##1 (i_flow.active && !i_flow.refill && i_code == 3'h1) |=> (o_flow.term && $past(o_flow.hold)))
        else $error("code one did not wait exactly one clock");
    seven_clock_wait_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE13
        (o_flow.term && $past(i_code) == 3'h7 && $past(state) == WT_WAIT)
        |-> ($past(o_flow.hold, 1) && $past(o_flow.hold, 7) && !$past(o_flow.hold, 8)))
        else $error("code seven wait was not seven clocks");
    count_range_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE15
        (state == WT_WAIT) |-> (cnt != 3'h0 && cnt <= i_code && o_flow.hold))
        else $error("wait count outside coded range");

endmodule // flow_wait_timer

// ===== src/secondary_prefetch_flow_control.sv
// Secondary prefetch limit and flow-through wait control with its Avalon-MM register slave
//
// Behaviour
// RULE1: Six-bit limit caps prefetch Dwords per read entry without flow-through; resets 20h.
// RULE2: Lowest bit of the prefetch limit is read-only zero.
// RULE3: Limit value zero means the largest amount, 256 bytes.
// RULE4: Software should program only even prefetch limits.
// RULE5: Reserved bits of both registers read back as zero.
// RULE6: Three-bit code sets clocks waited for more posted-write data.
// RULE7: Posted-write wait expiry ends the target cycle; rest is written later.
// RULE8: Posted-write code 000 ends the cycle with one queue entry left.
// RULE9: Posted-write code 001 stalls one clock; code 111 stalls seven.
// RULE10: Three-bit code sets clocks waited for read queue space.
// RULE11: Read wait expiry ends the cycle; initiator retry fetches the rest.
// RULE12: Read code 000 ends the cycle with one queue entry left.
// RULE13: Read code 001 stalls one clock; code 111 stalls seven.
// RULE14: Incremental count above half the limit disables incremental prefetch.
// RULE15: Codes 010 to 110 wait as many clocks as their value.
`timescale 1ns/1ps
module secondary_prefetch_flow_control (
    input  wire logic                          i_clk,
    input  wire logic                          i_sys_rst,
    input  wire logic [sec_pf_pkg::ADDR_W-1:0] i_address,
    input  wire logic                          i_read,
    input  wire logic                          i_write,
    input  wire logic [sec_pf_pkg::DATA_W-1:0] i_writedata,
    input  wire logic [3:0]                    i_byteenable,
    output      logic [sec_pf_pkg::DATA_W-1:0] o_readdata,
    output      logic                          o_waitrequest,
    input  wire sec_pf_pkg::flow_in_t          i_pw,
    input  wire sec_pf_pkg::flow_in_t          i_dr,
    output      sec_pf_pkg::flow_out_t         o_pw,
    output      sec_pf_pkg::flow_out_t         o_dr,
    input  wire logic                          i_rd_entry_start,
    input  wire logic                          i_rd_flowthrough,
    input  wire logic                          i_pf_alloc,
    input  wire logic [6:0]                    i_pf_alloc_dwords,
    output      logic                          o_pf_allow,
    output      logic [6:0]                    o_pf_max_dwords,
    output      logic                          o_incr_enable
);
    import sec_pf_pkg::*;

    // ------------------------------------------------------------------
    // Register bus slave
    // ------------------------------------------------------------------
    bus_state_t              bus_state;
    bus_state_t              next_bus_state;
    logic [DATA_W-1:0]       next_readdata;
    logic                    next_waitrequest;
    logic [5:0]              max_field;
    logic [5:0]              next_max_field;
    logic [5:0]              incr_field;
    logic [5:0]              next_incr_field;
    logic [2:0]              pw_wait;
    logic [2:0]              next_pw_wait;
    logic [2:0]              dr_wait;
    logic [2:0]              next_dr_wait;
    logic [3:0]              status;
    logic                    wr_lane0;

    assign status   = {o_incr_enable, !o_pf_allow, o_dr.hold, o_pw.hold};
    assign wr_lane0 = (bus_state == BUS_ACK) && i_write && i_byteenable[0];

    always_comb begin
        next_bus_state   = bus_state;
        next_readdata    = o_readdata;
        next_waitrequest = 1'b1;
        next_max_field   = max_field;
        next_incr_field  = incr_field;
        next_pw_wait     = pw_wait;
        next_dr_wait     = dr_wait;
        case (bus_state)
            BUS_IDLE: begin
                if (i_read || i_write) begin
                    // Read data is latched here so it stands through the answer cycle
                    next_bus_state   = BUS_ACK;
                    next_waitrequest = 1'b0;
                    case (i_address)
                        ADDR_INCR: next_readdata = {26'h0, incr_field};
                        ADDR_MAX:  next_readdata = {26'h0, max_field}; // see RULE5
                        ADDR_FLOW: next_readdata = {25'h0, dr_wait, 1'b0, pw_wait}; // see RULE5
                        ADDR_STAT: next_readdata = {28'h0, status};
                        default:   next_readdata = 32'h0;
                    endcase
                end
            end
            BUS_ACK: begin
                next_bus_state = BUS_IDLE;
                if (wr_lane0) begin
                    case (i_address)
                        ADDR_INCR: next_incr_field = {i_writedata[5:1], 1'b0};
                        ADDR_MAX:  next_max_field  = {i_writedata[5:1], 1'b0}; // see RULE1 see RULE2
                        ADDR_FLOW: begin
                            next_pw_wait = i_writedata[PW_WAIT_LSB +: 3]; // see RULE6
                            next_dr_wait = i_writedata[DR_WAIT_LSB +: 3]; // see RULE10
                        end
                        default: begin
                            next_pw_wait = pw_wait;
                        end
                    endcase
                end
            end
            default: begin
                next_bus_state = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            bus_state     <= BUS_IDLE;
            o_readdata    <= 32'h0;
            o_waitrequest <= 1'b1;
            max_field     <= RST_MAX; // see RULE1
            incr_field    <= RST_INCR;
            pw_wait       <= RST_PW_WAIT;
            dr_wait       <= RST_DR_WAIT;
        end else begin
            bus_state     <= next_bus_state;
            o_readdata    <= next_readdata;
            o_waitrequest <= next_waitrequest;
            max_field     <= next_max_field;
            incr_field    <= next_incr_field;
            pw_wait       <= next_pw_wait;
            dr_wait       <= next_dr_wait;
        end
    end

    // ------------------------------------------------------------------
    // Prefetch limit per read entry
    // ------------------------------------------------------------------
    logic [6:0] max_eff;
    logic [7:0] pf_used;
    logic [7:0] next_pf_used;
    logic [8:0] pf_sum;
    logic       next_pf_allow;
    logic [6:0] next_pf_max_dwords;
    logic       next_incr_enable;

    // Saturating count, an entry can never wrap back under its cap
    assign pf_sum  = {1'b0, pf_used} + {2'b00, i_pf_alloc_dwords};
    assign max_eff = (max_field == 6'h0) ? MAX_PF_DWORDS : {1'b0, max_field}; // see RULE3

    always_comb begin
        next_pf_used = pf_used;
        if (i_rd_entry_start) begin
            next_pf_used = 8'h00;
        end else if (i_pf_alloc) begin
            next_pf_used = pf_sum[8] ? USED_SAT : pf_sum[7:0];
        end
        // Flow-through entries stream freely, only entries without flow-through are capped
        next_pf_allow      = i_rd_flowthrough || (next_pf_used < {1'b0, max_eff}); // see RULE1
        next_pf_max_dwords = max_eff;
        next_incr_enable   = ({1'b0, incr_field} <= (max_eff >> 1)); // see RULE14
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pf_used         <= 8'h00;
            o_pf_allow      <= 1'b1;
            o_pf_max_dwords <= 7'h00;
            o_incr_enable   <= 1'b0;
        end else begin
            pf_used         <= next_pf_used;
            o_pf_allow      <= next_pf_allow;
            o_pf_max_dwords <= next_pf_max_dwords;
            o_incr_enable   <= next_incr_enable;
        end
    end

    // ------------------------------------------------------------------
    // Flow-through wait timers
    // ------------------------------------------------------------------
    flow_wait_timer u_pw_timer (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_code    (pw_wait),
        .i_flow    (i_pw),
        .o_flow    (o_pw)
    );

    flow_wait_timer u_dr_timer (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_code    (dr_wait),
        .i_flow    (i_dr),
        .o_flow    (o_dr)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    max_write_lsb_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE2
        (wr_lane0 && i_address == ADDR_MAX) |=> (max_field == {$past(i_writedata[5:1]), 1'b0}))
        else $error("prefetch limit write not stored with bit zero clear");
    zero_limit_max_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE3
        (max_field == 6'h0) ##1 (max_field == 6'h0) |-> (o_pf_max_dwords == MAX_PF_DWORDS))
        else $error("zero limit not treated as 256 bytes");
    reserved_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE5
        (bus_state == BUS_ACK && (i_address == ADDR_MAX || i_address == ADDR_FLOW))
        |-> (o_readdata[31:7] == 25'h0 && o_readdata[6] == (i_address == ADDR_FLOW && o_readdata[6])
             && (i_address != ADDR_FLOW || o_readdata[3] == 1'b0)))
        else $error("reserved bits read as nonzero");
    flow_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE6
        (wr_lane0 && i_address == ADDR_FLOW)
        |=> (pw_wait == $past(i_writedata[2:0]) && dr_wait == $past(i_writedata[6:4])))
        else $error("wait codes not stored on write");
    prefetch_cap_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE1
        (!i_rd_flowthrough && next_pf_used >= {1'b0, max_eff}) |=> !o_pf_allow)
        else $error("prefetch allowed past the limit");
    incr_gate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE14
        ({1'b0, incr_field} > (max_eff >> 1)) |=> !o_incr_enable)
        else $error("incremental prefetch left enabled above half the limit");
    bus_answer_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (bus_state == BUS_IDLE && (i_read || i_write)) |=> (!o_waitrequest ##1 o_waitrequest))
        else $error("bus answer not a single cycle");

endmodule // secondary_prefetch_flow_control

// ===== tb/flow_partner.sv
// Far-side model of a secondary-bus burst source or sink feeding one wait timer
`timescale 1ns/1ps
module flow_partner (
    input  wire logic                  i_clk,
    input  wire logic                  i_sys_rst,
    input  wire logic                  i_start,
    input  wire logic [6:0]            i_level,
    input  wire logic [4:0]            i_refill_at,
    input  wire sec_pf_pkg::flow_out_t i_resp,
    output      sec_pf_pkg::flow_in_t  o_flow
);
    import sec_pf_pkg::*;

    logic [4:0] cyc;
    logic       refill_now;

    assign refill_now = (i_refill_at != 5'h00) && (cyc + 5'h01 == i_refill_at);

    // ------------------------------------------------------------------
    // Burst sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_flow <= '0;
            cyc    <= 5'h00;
        end else if (!o_flow.active) begin
            // Idle queue level is junk, never the last value
            o_flow.level  <= ~o_flow.level;
            o_flow.refill <= 1'b0;
            if (i_start) begin
                o_flow.active <= 1'b1;
                o_flow.level  <= i_level;
                cyc           <= 5'h00;
            end
        end else begin
            cyc           <= cyc + 5'h01;
            o_flow.refill <= refill_now;
            if (refill_now) begin
                o_flow.level <= 7'h02;
            end
            // Cut burst ends here; the rest comes back as a retry
            if (i_resp.term || cyc == 5'h14) begin
                o_flow.active <= 1'b0;
            end
        end
    end
endmodule // flow_partner

// ===== tb/secondary_prefetch_flow_control_tb.sv
// Self-checking bench for the secondary prefetch and flow-through control block
`timescale 1ns/1ps
module secondary_prefetch_flow_control_tb;
    import sec_pf_pkg::*;

    logic              i_clk = 1'b0;
    logic              i_sys_rst = 1'b1;
    logic [ADDR_W-1:0] i_address = '0;
    logic              i_read = 1'b0;
    logic              i_write = 1'b0;
    logic [DATA_W-1:0] i_writedata = '0;
    logic [3:0]        i_byteenable = 4'h0;
    logic [DATA_W-1:0] o_readdata;
    logic              o_waitrequest;
    flow_in_t          i_pw;
    flow_in_t          i_dr;
    flow_out_t         o_pw;
    flow_out_t         o_dr;
    logic              i_rd_entry_start = 1'b0;
    logic              i_rd_flowthrough = 1'b0;
    logic              i_pf_alloc = 1'b0;
    logic [6:0]        i_pf_alloc_dwords = 7'h00;
    logic              o_pf_allow;
    logic [6:0]        o_pf_max_dwords;
    logic              o_incr_enable;
    logic              pw_go = 1'b0;
    logic              dr_go = 1'b0;
    logic [6:0]        go_level = 7'h00;
    logic [4:0]        go_refill = 5'h00;
    logic [31:0]       rd;
    int                miscompares = 0;
    int                checks = 0;
    int                cycles = 0;

    always #12.5 i_clk = ~i_clk;

    secondary_prefetch_flow_control dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_pw(i_pw), .i_dr(i_dr), .o_pw(o_pw),
        .o_dr(o_dr), .i_rd_entry_start(i_rd_entry_start), .i_rd_flowthrough(i_rd_flowthrough),
        .i_pf_alloc(i_pf_alloc), .i_pf_alloc_dwords(i_pf_alloc_dwords), .o_pf_allow(o_pf_allow),
        .o_pf_max_dwords(o_pf_max_dwords), .o_incr_enable(o_incr_enable));
    flow_partner pw_side (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_start(pw_go), .i_level(go_level),
        .i_refill_at(go_refill), .i_resp(o_pw), .o_flow(i_pw));
    flow_partner dr_side (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_start(dr_go), .i_level(go_level),
        .i_refill_at(go_refill), .i_resp(o_dr), .o_flow(i_dr));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic results;
        if (miscompares == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Held until waitrequest is seen low at a rising edge, then released
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] be);
        logic got;
        got = 1'b0;
        @(posedge i_clk);
        i_address    <= a;
        i_writedata  <= {24'h000000, d};
        i_byteenable <= be;
        i_write      <= wr;
        i_read       <= ~wr;
        while (!got) begin
            @(posedge i_clk);
            got = (o_waitrequest === 1'b0);
            if (got) begin
                rd = o_readdata;
            end
        end
        i_write <= 1'b0;
        i_read  <= 1'b0;
    endtask

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 8'h00, 4'hf);
        chk(what, rd, exp);
    endtask

    task automatic settle;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
    endtask

    // Starts one burst and counts hold cycles and the cycle of the end pulse
    task automatic timer(input logic dr, input logic [2:0] code, input logic [6:0] lvl, input logic [4:0] rf,
                         output int term_at, output int holds);
        flow_out_t o;
        bus(1'b1, ADDR_FLOW, {1'b0, code, 1'b0, code}, 4'h1);
        @(posedge i_clk);
        go_level  <= lvl;
        go_refill <= rf;
        dr_go     <= dr;
        pw_go     <= ~dr;
        @(posedge i_clk);
        dr_go <= 1'b0;
        pw_go <= 1'b0;
        term_at = 0;
        holds   = 0;
        for (int k = 1; k < 40; k++) begin
            @(negedge i_clk);
            o = dr ? o_dr : o_pw;
            holds += int'(o.hold === 1'b1);
            if (o.term === 1'b1 && term_at == 0) term_at = k;
        end
    endtask

    // Long enough for all scenarios, short enough to catch a stuck handshake
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            results();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        int t;
        int h;
        repeat (5) @(posedge i_clk);
        @(negedge i_clk);
        chk("reset waitrequest", {31'h0, o_waitrequest}, 32'h1);
        @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rdchk(ADDR_MAX, 32'h20, "limit reset");
        rdchk(ADDR_FLOW, 32'h00, "flow reset");
        rdchk(ADDR_INCR, 32'h10, "incr reset");
        bus(1'b1, ADDR_MAX, 8'hff, 4'h1);
        rdchk(ADDR_MAX, 32'h3e, "limit odd write");
        bus(1'b1, ADDR_FLOW, 8'hff, 4'h1);
        rdchk(ADDR_FLOW, 32'h77, "flow reserved");
        bus(1'b1, ADDR_MAX, 8'h00, 4'h0);
        rdchk(ADDR_MAX, 32'h3e, "limit no byte");
        rdchk(10'h000, 32'h00, "unmapped");
        bus(1'b1, ADDR_MAX, 8'h00, 4'h1);
        settle();
        chk("zero limit dwords", {25'h0, o_pf_max_dwords}, 32'h40);
        chk("incr under big limit", {31'h0, o_incr_enable}, 32'h1);
        bus(1'b1, ADDR_MAX, 8'h04, 4'h1);
        settle();
        chk("incr over half", {31'h0, o_incr_enable}, 32'h0);
        bus(1'b1, ADDR_INCR, 8'h02, 4'h1);
        settle();
        chk("incr at half", {31'h0, o_incr_enable}, 32'h1);
        @(posedge i_clk);
        i_rd_entry_start <= 1'b1;
        @(posedge i_clk);
        i_rd_entry_start  <= 1'b0;
        i_pf_alloc        <= 1'b1;
        i_pf_alloc_dwords <= 7'h02;
        @(posedge i_clk);
        i_pf_alloc <= 1'b0;
        settle();
        chk("allow below cap", {31'h0, o_pf_allow}, 32'h1);
        @(posedge i_clk);
        i_pf_alloc <= 1'b1;
        @(posedge i_clk);
        i_pf_alloc <= 1'b0;
        settle();
        chk("allow at cap", {31'h0, o_pf_allow}, 32'h0);
        rdchk(ADDR_STAT, 32'h0c, "status capped");
        @(posedge i_clk);
        i_rd_flowthrough <= 1'b1;
        settle();
        chk("allow flow-through", {31'h0, o_pf_allow}, 32'h1);
        rdchk(ADDR_STAT, 32'h08, "status free");
        for (int n = 0; n < 8; n++) begin
            for (int s = 0; s < 2; s++) begin
                timer(s[0], n[2:0], (n == 0) ? 7'h01 : 7'h00, 5'h00, t, h);
                chk(s ? "read term" : "write term", t, n + 2);
                chk(s ? "read hold" : "write hold", h, n);
            end
        end
        for (int s = 0; s < 2; s++) begin
            timer(s[0], 3'h5, 7'h00, 5'h03, t, h);
            chk(s ? "read refill term" : "write refill term", t, 0);
            chk(s ? "read refill hold" : "write refill hold", h, 3);
        end
        results();
    end
endmodule // secondary_prefetch_flow_control_tb
